// ---- acgs_pkg.sv ----
// acgs_pkg: constants and types for the channel sequence table block
// assumes a single 125 MHz clock and the plain command port of the top module
package acgs_pkg;
    localparam int          ACGS_DEPTH     = 1024;
    localparam int          ACGS_AW        = 10;
    localparam int          ACGS_SET_W     = 16;
    localparam int          ACGS_DIG_W     = 8;
    // command port addresses (function codes)
    localparam logic [15:0] ACGS_F_SETTING = 16'h0300;
    localparam logic [15:0] ACGS_F_LATCH   = 16'h0301;
    localparam logic [15:0] ACGS_F_DIGITAL = 16'h0302;
    localparam logic [15:0] ACGS_F_TBL_EN  = 16'h0303;
    localparam logic [15:0] ACGS_F_DIG_EN  = 16'h0304;
    localparam logic [15:0] ACGS_F_PAUSE   = 16'h0305;
    localparam logic [15:0] ACGS_F_RESET   = 16'h030e;
    localparam logic [15:0] ACGS_F_CLEAR   = 16'h030f;
    localparam logic [15:0] ACGS_F_STATUS  = 16'h0310;
    localparam logic [15:0] ACGS_F_CURRENT = 16'h0311;
    // setting word field positions
    localparam int          ACGS_B_CHAN_LO = 0;
    localparam int          ACGS_B_CHAN_HI = 3;
    localparam int          ACGS_B_DIFFERENTIAL_INPUT    = 3;
    localparam int          ACGS_B_PAUSE   = 11;
    localparam int          ACGS_B_UPD1    = 12;
    localparam int          ACGS_B_UPD2    = 13;
    localparam int          ACGS_B_SKIP    = 14;
    localparam int          ACGS_SE_HALF   = 8;
    // reset values
    localparam logic [15:0] ACGS_SET_RST   = 16'h0000;
    localparam logic [7:0]  ACGS_DIG_RST   = 8'h00;

    typedef struct packed {
        logic [15:0] addr;
        logic [15:0] wdata;
        logic        wr;
        logic        rd;
    } acgs_cmd_s;

    typedef struct packed {
        logic [10:0] conv;      // channel, gain, range, type
        logic        upd1;
        logic        upd2;
        logic        skip;
        logic        chan_ok;
        logic [7:0]  dig;
        logic        dig_en;
    } acgs_conv_s;
endpackage

// ---- acgs_sequencer.sv ----
// acgs_sequencer: 1024-entry channel sequence table, single setting latch and sequencer
// assumes triggers and conversion clock pulses arrive as one-cycle pulses in the clk domain
//
// Function
// - table holds up to 1024 entries of 24 bits
// - each entry: 16-bit setting word beside an 8-bit digital byte
// - clear command empties table; both append positions restart at entry zero
// - writes after the last entry is filled are dropped
// - setting writes append at next free entry
// - bits 0..10 give channel, gain, range and type per entry
// - mux offers 16 single-ended or 8 differential inputs
// - differential channel n blocks single-ended channel n+8
// - pause bit with pause enabled halts until next start trigger
// - pause ignored in burst mode and in latch operation
// - bits 12/13 pulse converter update strobes at that sample
// - bit 14 converts but withholds the FIFO write
// - each conversion pulse uses current entry then advances
// - after last loaded entry wrap to first until stop
// - digital writes use their own append position
// - n-th digital byte pairs with n-th setting word
// - digital enable drives entry byte onto second digital port
// - digital enable covers the whole sequence only
// - latch holds one setting for single-channel mode
// - table governs conversions only after table enable
// - digital output acts only while table enabled
// - table reset returns position to first entry, keeps data
//
// The plain strobed port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module acgs_sequencer
    import acgs_pkg::*;
(
    // clock and reset
    input  wire logic                clk,
    input  wire logic                nrst,
    // command port
    input  wire acgs_pkg::acgs_cmd_s cmd,
    output logic [15:0]              rdata,
    // acquisition control
    input  wire logic                conv_pulse,
    input  wire logic                start_trig,
    input  wire logic                stop_trig,
    input  wire logic                burst_mode,
    // conversion outputs
    output acgs_pkg::acgs_conv_s     conv_out,
    output logic                     conv_strobe,
    output logic                     fifo_wr,
    output logic [7:0]               port2_out,
    output logic                     paused,
    output logic                     running
);
    import acgs_pkg::*;

    logic [ACGS_SET_W-1:0] set_mem [ACGS_DEPTH];
    logic [ACGS_DIG_W-1:0] dig_mem [ACGS_DEPTH];
    logic [ACGS_AW:0]      set_cnt;
    logic [ACGS_AW:0]      dig_cnt;
    logic [ACGS_AW-1:0]    pos;
    logic [15:0]           latch;
    logic                  tbl_en;
    logic                  dig_en;
    logic                  pause_en;
    logic                  hold;
    logic [ACGS_SE_HALF-1:0] differential_input_seen;

    logic                  wr_set;
    logic                  wr_dig;
    logic                  use_tbl;
    logic [15:0]           cur;
    logic [7:0]            cur_dig;
    logic                  chan_ok;
    logic                  last_pos;
    logic                  fire;

    assign wr_set   = cmd.wr && cmd.addr == ACGS_F_SETTING && set_cnt < ACGS_DEPTH[ACGS_AW:0];
    assign wr_dig   = cmd.wr && cmd.addr == ACGS_F_DIGITAL && dig_cnt < ACGS_DEPTH[ACGS_AW:0];
    assign use_tbl  = tbl_en && set_cnt != '0;
    assign cur      = use_tbl ? set_mem[pos] : latch;
    assign cur_dig  = dig_mem[pos];
    assign last_pos = {1'b0, pos} + 11'd1 >= set_cnt;
    assign fire     = conv_pulse && running && !hold;

    // differential on lower channel consumes upper input as negative leg
    // bit 10 marks a differential entry; its upper partner input is then taken
    always_comb begin
        chan_ok = 1'b1;
        // single-ended pick of an upper input already owned as a negative leg
        if (!cur[ACGS_B_DIFFERENTIAL_INPUT + 7] && cur[ACGS_B_CHAN_HI] && differential_input_seen[cur[2:0]]) begin
            chan_ok = 1'b0;
        end
    end

    // entry storage, one write port per portion
    always_ff @(posedge clk) begin
        if (wr_set) begin
            set_mem[set_cnt[ACGS_AW-1:0]] <= cmd.wdata;
        end
        if (wr_dig) begin
            dig_mem[dig_cnt[ACGS_AW-1:0]] <= cmd.wdata[7:0];
        end
    end

    // append positions
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            set_cnt <= '0;
            dig_cnt <= '0;
        end else if (cmd.wr && cmd.addr == ACGS_F_CLEAR) begin
            set_cnt <= '0;
            dig_cnt <= '0;
        end else begin
            if (wr_set) begin
                set_cnt <= set_cnt + 11'd1;
            end
            if (wr_dig) begin
                dig_cnt <= dig_cnt + 11'd1;
            end
        end
    end

    // control bits and latch
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            tbl_en   <= 1'b0;
            dig_en   <= 1'b0;
            pause_en <= 1'b0;
            latch    <= ACGS_SET_RST;
        end else if (cmd.wr) begin
            case (cmd.addr)
                ACGS_F_LATCH:  latch    <= cmd.wdata;
                ACGS_F_TBL_EN: tbl_en   <= cmd.wdata[0];
                ACGS_F_DIG_EN: dig_en   <= cmd.wdata[0];
                ACGS_F_PAUSE:  pause_en <= cmd.wdata[0];
                default: ;
            endcase
        end
    end

    // run state: start opens, stop closes, pause waits for a start
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            running <= 1'b0;
            hold    <= 1'b0;
        end else begin
            if (stop_trig) begin
                running <= 1'b0;
            end else if (start_trig) begin
                running <= 1'b1;
            end
            if (start_trig) begin
                hold <= 1'b0;
            end else if (fire && use_tbl && pause_en && !burst_mode && cur[ACGS_B_PAUSE]) begin
                hold <= 1'b1;
            end
        end
    end

    // sequencing position
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            pos <= '0;
        end else if (cmd.wr && (cmd.addr == ACGS_F_RESET || cmd.addr == ACGS_F_CLEAR)) begin
            pos <= '0;
        end else if (fire && use_tbl) begin
            pos <= last_pos ? '0 : pos + 10'd1;
        end
    end

    // conversion outputs, registered at the sampling instant
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            conv_out    <= '0;
            conv_strobe <= 1'b0;
            fifo_wr     <= 1'b0;
            port2_out   <= ACGS_DIG_RST;
        end else begin
            conv_strobe <= fire;
            fifo_wr     <= fire && !cur[ACGS_B_SKIP];
            if (fire) begin
                conv_out.conv    <= cur[10:0];
                conv_out.upd1    <= cur[ACGS_B_UPD1];
                conv_out.upd2    <= cur[ACGS_B_UPD2];
                conv_out.skip    <= cur[ACGS_B_SKIP];
                conv_out.chan_ok <= chan_ok;
                conv_out.dig     <= cur_dig;
                conv_out.dig_en  <= dig_en && use_tbl;
                if (dig_en && use_tbl) begin
                    port2_out <= cur_dig;
                end
            end else begin
                conv_out.upd1 <= 1'b0;
                conv_out.upd2 <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            paused <= 1'b0;
        end else begin
            paused <= hold;
        end
    end

    // read port, data valid the cycle after the strobe
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rdata <= '0;
        end else if (cmd.rd) begin
            case (cmd.addr)
                ACGS_F_STATUS:  rdata <= {hold, running, pause_en, dig_en, tbl_en, set_cnt};
                ACGS_F_CURRENT: rdata <= {6'h00, pos};
                ACGS_F_LATCH:   rdata <= latch;
                default:        rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end

    // cross-channel check: a differential setting on channel n makes input n+8 unusable
    // only table writes are tracked; the latch alone cannot claim a negative leg
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            differential_input_seen <= '0;
        end else if (cmd.wr && cmd.addr == ACGS_F_CLEAR) begin
            differential_input_seen <= '0;
        end else if (wr_set && cmd.wdata[ACGS_B_DIFFERENTIAL_INPUT + 7]) begin
            differential_input_seen[cmd.wdata[2:0]] <= 1'b1;
        end
    end

    a_skip_fifo: assert property (@(posedge clk) disable iff (!nrst)
        fire && cur[ACGS_B_SKIP] |=> conv_strobe && !fifo_wr) else $error("skipped entry wrote fifo");
    a_strobe_fifo: assert property (@(posedge clk) disable iff (!nrst)
        fifo_wr |-> conv_strobe) else $error("fifo write without conversion");
    a_pos_wrap: assert property (@(posedge clk) disable iff (!nrst)
        fire && use_tbl && last_pos && !cmd.wr |=> pos == '0) else $error("no wrap after last entry");
    a_pos_step: assert property (@(posedge clk) disable iff (!nrst)
        fire && use_tbl && !last_pos && !cmd.wr |=> pos == $past(pos) + 10'd1) else $error("no step");
    a_pause_hold: assert property (@(posedge clk) disable iff (!nrst)
        hold && !start_trig |=> !conv_strobe) else $error("converted while paused");
    a_full_drop: assert property (@(posedge clk) disable iff (!nrst)
        set_cnt == ACGS_DEPTH[ACGS_AW:0] && !(cmd.wr && cmd.addr == ACGS_F_CLEAR) |=> $stable(set_cnt))
        else $error("append past end");
    a_clear_cnt: assert property (@(posedge clk) disable iff (!nrst)
        cmd.wr && cmd.addr == ACGS_F_CLEAR |=> set_cnt == '0 && dig_cnt == '0 && pos == '0)
        else $error("clear did not empty table");
    a_dig_gate: assert property (@(posedge clk) disable iff (!nrst)
        fire && !(dig_en && use_tbl) |=> $stable(port2_out)) else $error("digital port driven while off");
    a_upd_strobe: assert property (@(posedge clk) disable iff (!nrst)
        fire && cur[ACGS_B_UPD1] |=> conv_out.upd1)
        else $error("update strobe missing");

    // update strobes last one cycle: no conversion, no strobe
    a_upd_pulse: assert property (@(posedge clk) disable iff (!nrst)
        !fire
        |=> !conv_out.upd1 && !conv_out.upd2)
        else $error("update strobe too long");

    a_upd2_strobe: assert property (@(posedge clk) disable iff (!nrst)
        fire && cur[ACGS_B_UPD2]
        |=> conv_out.upd2)
        else $error("second update strobe missing");

    // conversion strobe follows each taken pulse and nothing else
    a_strobe_fire: assert property (@(posedge clk) disable iff (!nrst)
        fire
        |=> conv_strobe)
        else $error("taken pulse gave no conversion");

    a_quiet_idle: assert property (@(posedge clk) disable iff (!nrst)
        !fire
        |=> !conv_strobe && !fifo_wr)
        else $error("conversion without pulse");

    // append counters step by one per accepted write
    a_set_append: assert property (@(posedge clk) disable iff (!nrst)
        wr_set
        |=> set_cnt == $past(set_cnt) + 11'd1)
        else $error("setting write did not append");

    a_dig_append: assert property (@(posedge clk) disable iff (!nrst)
        wr_dig
        |=> dig_cnt == $past(dig_cnt) + 11'd1)
        else $error("digital write did not append");

    a_dig_full: assert property (@(posedge clk) disable iff (!nrst)
        dig_cnt == ACGS_DEPTH[ACGS_AW:0] && !(cmd.wr && cmd.addr == ACGS_F_CLEAR)
        |=> $stable(dig_cnt))
        else $error("digital append past end");

    a_reset_pos: assert property (@(posedge clk) disable iff (!nrst)
        cmd.wr && cmd.addr == ACGS_F_RESET
        |=> pos == '0 && set_cnt == $past(set_cnt))
        else $error("table reset misbehaved");

    // latch mode leaves the table position alone
    a_latch_pos: assert property (@(posedge clk) disable iff (!nrst)
        fire && !use_tbl && !cmd.wr
        |=> $stable(pos))
        else $error("position moved in latch mode");

    a_latch_conv: assert property (@(posedge clk) disable iff (!nrst)
        fire && !use_tbl
        |=> conv_out.conv == $past(latch[10:0]))
        else $error("latch setting not applied");

    a_tbl_conv: assert property (@(posedge clk) disable iff (!nrst)
        fire && use_tbl
        |=> conv_out.conv == $past(cur[10:0]))
        else $error("entry setting not applied");

    // pause can never be entered in burst mode or from the latch
    a_burst_nohold: assert property (@(posedge clk) disable iff (!nrst)
        !hold && (burst_mode || !use_tbl)
        |=> !hold)
        else $error("pause taken where it has no effect");

    a_stop_wins: assert property (@(posedge clk) disable iff (!nrst)
        stop_trig
        |=> !running)
        else $error("stop trigger ignored");

    a_dig_drive: assert property (@(posedge clk) disable iff (!nrst)
        fire && dig_en && use_tbl
        |=> port2_out == $past(cur_dig))
        else $error("entry byte not on digital port");

    a_chan_block: assert property (@(posedge clk) disable iff (!nrst)
        fire && !chan_ok
        |=> !conv_out.chan_ok)
        else $error("blocked input reported usable");

    a_paused_lag: assert property (@(posedge clk) disable iff (!nrst)
        1'b1
        |=> paused == $past(hold))
        else $error("paused flag out of step");
endmodule // acgs_sequencer

// ---- acgs_host_model.sv ----
// acgs_host_model: host software issuing commands on the sequencer command port
// assumes tb_top calls its tasks and shares the sequencer clock
`timescale 1ns/1ns
module acgs_host_model
    import acgs_pkg::*;
(
    // clock
    input  wire logic           clk,
    // command port
    output acgs_pkg::acgs_cmd_s cmd,
    input  wire logic [15:0]    rdata
);
    initial cmd = '0;

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk) cmd <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) cmd <= '{a, d, 1'b0, 1'b0};
    endtask

    // data stands only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, output logic [15:0] d);
        @(posedge clk) cmd <= '{a, 16'h0000, 1'b0, 1'b1};
        @(posedge clk) cmd <= '{a, 16'h0000, 1'b0, 1'b0};
        #1 d = rdata;
    endtask

    // bytes go after all words: pairing must not hang on order
    task automatic load(input logic [15:0] s[4], input logic [7:0] g[4], input int n);
        wr(ACGS_F_CLEAR, 16'h0000);
        for (int i = 0; i < n; i++) begin
            wr(ACGS_F_SETTING, s[i]);
        end
        for (int i = 0; i < n; i++) begin
            wr(ACGS_F_DIGITAL, {8'h00, g[i]});
        end
    endtask
endmodule // acgs_host_model

// ---- tb_top.sv ----
// tb_top: self-checking bench for the channel sequence table
// assumes acgs_host_model drives the command port
`timescale 1ns/1ns
module tb_top;
    import acgs_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic        conv_pulse = 1'b0;
    logic        start_trig = 1'b0;
    logic        stop_trig = 1'b0;
    logic        burst_mode = 1'b0;
    acgs_cmd_s   cmd;
    acgs_conv_s  conv_out;
    logic [15:0] rdata;
    logic        conv_strobe;
    logic        fifo_wr;
    logic [7:0]  port2_out;
    logic        paused;
    logic        running;
    logic [15:0] set_w [4] = '{16'h0001, 16'h4005, 16'h3802, 16'h0807};
    logic [7:0]  dig_w [4] = '{8'ha5, 8'h3c, 8'hf0, 8'h00};
    int          fail_count = 0;
    int          checked = 0;

    always #4 clk = ~clk;

    acgs_host_model i_acgs_host_model (.clk(clk), .cmd(cmd), .rdata(rdata));
    acgs_sequencer i_acgs_sequencer (.clk(clk), .nrst(nrst), .cmd(cmd), .rdata(rdata),
        .conv_pulse(conv_pulse), .start_trig(start_trig), .stop_trig(stop_trig),
        .burst_mode(burst_mode), .conv_out(conv_out), .conv_strobe(conv_strobe),
        .fifo_wr(fifo_wr), .port2_out(port2_out), .paused(paused), .running(running));

    task automatic chk(input string n, input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", n, exp, got);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic w(input logic [15:0] a, input logic [15:0] d);
        i_acgs_host_model.wr(a, d);
    endtask

    task automatic rc(input logic [15:0] a, input logic [15:0] e, input string n);
        logic [15:0] d;
        i_acgs_host_model.rd(a, d);
        chk(n, d, e);
    endtask

    task automatic trig(input logic stop);
        @(posedge clk) begin
            start_trig <= !stop;
            stop_trig <= stop;
        end
        @(posedge clk) begin
            start_trig <= 1'b0;
            stop_trig <= 1'b0;
        end
        @(posedge clk);
        #1;
    endtask

    // e below zero: entry unknown, strobe only
    task automatic step(input int e, input logic go);
        @(posedge clk) conv_pulse <= 1'b1;
        @(posedge clk) conv_pulse <= 1'b0;
        #1;
        chk("strobe", conv_strobe, go);
        if (go && e >= 0) begin
            chk("conv", conv_out.conv, set_w[e][10:0]);
            chk("fifo_wr", fifo_wr, !set_w[e][14]);
            chk("upd", {conv_out.upd2, conv_out.upd1}, set_w[e][13:12]);
            chk("port2", port2_out, dig_w[e]);
            chk("chan_ok", conv_out.chan_ok, 1'b1);
            chk("skip", conv_out.skip, set_w[e][14]);
            chk("dig_en", conv_out.dig_en, e < 3);
            if (e < 3) chk("dig", conv_out.dig, dig_w[e]);
        end
    endtask

    initial begin
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rc(ACGS_F_STATUS, 16'h0000, "status");
        rc(16'h0312, 16'h0000, "unmapped");
        i_acgs_host_model.load(set_w, dig_w, 3);
        rc(ACGS_F_STATUS, 16'h0003, "status");
        $display("test load done");
        w(ACGS_F_PAUSE, 16'h0001);
        w(ACGS_F_LATCH, set_w[3]);
        w(ACGS_F_DIG_EN, 16'h0001);
        trig(1'b0);
        step(3, 1'b1);
        step(3, 1'b1);
        rc(ACGS_F_CURRENT, 16'h0000, "position");
        $display("test latch done");
        w(ACGS_F_PAUSE, 16'h0000);
        w(ACGS_F_TBL_EN, 16'h0001);
        for (int i = 0; i < 5; i++) step(i % 3, 1'b1);
        rc(ACGS_F_CURRENT, 16'h0002, "position");
        trig(1'b1);
        chk("running", running, 1'b0);
        step(0, 1'b0);
        w(ACGS_F_RESET, 16'h0000);
        rc(ACGS_F_CURRENT, 16'h0000, "position");
        rc(ACGS_F_STATUS, 16'h1803, "status");
        $display("test table done");
        w(ACGS_F_PAUSE, 16'h0001);
        @(posedge clk) burst_mode <= 1'b1;
        trig(1'b0);
        for (int i = 0; i < 4; i++) step(i % 3, 1'b1);
        @(posedge clk) burst_mode <= 1'b0;
        step(1, 1'b1);
        step(2, 1'b1);
        for (int k = 0; k < 4 && paused !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        chk("paused", paused, 1'b1);
        if (paused !== 1'b1) tally_and_finish();
        step(-1, 1'b0);
        trig(1'b0);
        chk("paused", paused, 1'b0);
        step(-1, 1'b1);
        trig(1'b1);
        $display("test pause done");
        w(ACGS_F_CLEAR, 16'h0000);
        rc(ACGS_F_STATUS, 16'h3800, "status");
        for (int i = 0; i < 1025; i++) w(ACGS_F_SETTING, 16'(i));
        rc(ACGS_F_STATUS, 16'h3c00, "status");
        $display("test full done");
        tally_and_finish();
    end
endmodule // tb_top
